// ---- rtl/mmbe_engine.sv ----
/*
 * Branch second-word handling and memory-to-memory move engine.
 * Assumes the script fetcher presents all instruction words at once with
 * the pointer to the next sequential instruction, and a simple system bus
 * with a grant and a per-transfer acknowledge.
 */
`timescale 1ns/100ps
`default_nettype none
module mmbe_engine
   import mmbe_pkg::*;
#(
   parameter logic [31:0] REG_BASE  = 32'hFFFF_FF00,
   parameter logic [31:0] REG_SPAN  = 32'h0000_0080,
   parameter int          FIFO_DEPTH = 8
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        insn_valid,
   input  wire logic [31:0] insn_w0,
   input  wire logic [31:0] insn_w1,
   input  wire logic [31:0] insn_w2,
   input  wire logic [31:0] script_ptr,
   input  wire logic [2:0]  phase_lines,
   input  wire logic [7:0]  last_rx_byte,
   input  wire logic [1:0]  burst_sel,
   output logic             idle_ff,
   output logic             done_ff,
   output logic [31:0]      next_fetch_ff,
   output logic             int_req_ff,
   output logic             halt_ff,
   output logic             illegal_ff,
   output logic [31:0]      instr_reg_ff,
   output logic [31:0]      script_pointer_save_ff,
   output logic [31:0]      next_address_pointer_ff,
   output logic [31:0]      return_holder_ff,
   output logic [23:0]      byte_count_ff,
   output logic             bus_req_ff,
   input  wire logic        bus_gnt,
   output logic             bus_stb_ff,
   output logic             bus_we_ff,
   output logic             bus_byte_ff,
   output logic [31:0]      bus_addr_ff,
   output logic [31:0]      bus_wdata_ff,
   input  wire logic [31:0] bus_rdata,
   input  wire logic        bus_ack,
   output logic             reg_re_ff,
   output logic             reg_we_ff,
   output logic             reg_byte_ff,
   output logic [31:0]      reg_addr_ff,
   output logic [31:0]      reg_wdata_ff,
   input  wire logic [31:0] reg_rdata
);
   // ------------------------------------------------------------
   // Checks and local signals
   // ------------------------------------------------------------
   if (FIFO_DEPTH < 2 || FIFO_DEPTH > 16) begin : g_bad_depth
      $error("FIFO depth must lie between 2 and 16 words");
   end

   localparam logic [4:0] DEPTH5 = 5'(FIFO_DEPTH);

   mmbe_state_type state_ff;
   mmbe_state_type nxt_state;
   logic [4:0]     beats_ff;
   logic [4:0]     nxt_beats;
   logic [4:0]     chunk;
   logic [4:0]     burst_lw;
   logic           take;
   logic           ack;
   logic [31:0]    rd_data;
   logic           fifo_in_ready;
   logic           fifo_out_valid;
   logic [32:0]    fifo_out;
   logic           fifo_push;
   logic           fifo_pop;
   logic           xfer_busy;
   logic [31:0]    cur_addr;
   logic           cur_in_reg;
   logic           rd_byte;
   logic [2:0]     rd_sz;
   logic [2:0]     wr_sz;
   logic [31:0]    rel_target;

   logic           nxt_idle;
   logic           nxt_done;
   logic [31:0]    nxt_next_fetch;
   logic           nxt_int_req;
   logic           nxt_halt;
   logic           nxt_illegal;
   logic [31:0]    nxt_instr_reg;
   logic [31:0]    nxt_sps;
   logic [31:0]    nxt_src;
   logic [31:0]    nxt_dst;
   logic [23:0]    nxt_count;
   logic           nxt_bus_req;
   logic           nxt_bus_stb;
   logic           nxt_bus_we;
   logic           nxt_bus_byte;
   logic [31:0]    nxt_bus_addr;
   logic [31:0]    nxt_bus_wdata;
   logic           nxt_reg_re;
   logic           nxt_reg_we;
   logic           nxt_reg_byte;
   logic [31:0]    nxt_reg_addr;
   logic [31:0]    nxt_reg_wdata;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   mmbe_branch_eval u_eval (
      .first_word   (insn_w0),
      .phase_lines  (phase_lines),
      .last_rx_byte (last_rx_byte),
      .take         (take)
   );

   // FIFO holds one burst or one FIFO-sized piece of it; its entry is {single byte flag, data}
   mmbe_fifo #(
      .WIDTH (33),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .in_valid  (fifo_push),
      .in_ready  (fifo_in_ready),
      .in_data   ({rd_byte, rd_data}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out)
   );

   always_comb begin
      burst_lw = 5'h02 << burst_sel;
      // A burst larger than the FIFO is split into FIFO-sized pieces
      chunk    = (burst_lw > DEPTH5) ? DEPTH5 : burst_lw;
      ack      = (bus_stb_ff & bus_ack) | reg_re_ff | reg_we_ff;
      rd_data  = bus_stb_ff ? bus_rdata : reg_rdata;
      xfer_busy = bus_stb_ff | reg_re_ff | reg_we_ff;
      cur_addr = (state_ff == ST_WR_XFER) ? return_holder_ff
                                          : next_address_pointer_ff;
      cur_in_reg = (cur_addr >= REG_BASE)
                   && (cur_addr - REG_BASE < REG_SPAN);
      // Longword only when aligned with four or more bytes left
      rd_byte  = (byte_count_ff < 24'h00_0004)
                 || (next_address_pointer_ff[1:0] != 2'h0);
      rd_sz    = rd_byte ? SZ_BYTE : SZ_LWORD;
      wr_sz    = fifo_out[32] ? SZ_BYTE : SZ_LWORD;
      fifo_push = ack && (state_ff == ST_RD_XFER);
      fifo_pop  = ack && (state_ff == ST_WR_XFER);
      rel_target = script_ptr
                   + {{8{insn_w1[23]}}, insn_w1[23:0]};
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state      = state_ff;
      nxt_beats      = beats_ff;
      nxt_idle       = 1'b0;
      nxt_done       = 1'b0;
      nxt_int_req    = 1'b0;
      nxt_halt       = 1'b0;
      nxt_illegal    = 1'b0;
      nxt_next_fetch = next_fetch_ff;
      nxt_instr_reg  = instr_reg_ff;
      nxt_sps        = script_pointer_save_ff;
      nxt_src        = next_address_pointer_ff;
      nxt_dst        = return_holder_ff;
      nxt_count      = byte_count_ff;
      nxt_bus_stb    = bus_stb_ff & ~bus_ack;
      nxt_bus_we     = bus_we_ff;
      nxt_bus_byte   = bus_byte_ff;
      nxt_bus_addr   = bus_addr_ff;
      nxt_bus_wdata  = bus_wdata_ff;
      nxt_reg_re     = 1'b0;
      nxt_reg_we     = 1'b0;
      nxt_reg_byte   = reg_byte_ff;
      nxt_reg_addr   = reg_addr_ff;
      nxt_reg_wdata  = reg_wdata_ff;
      case (state_ff)
         ST_IDLE: begin
            nxt_idle = 1'b1;
            if (insn_valid) begin
               nxt_idle       = 1'b0;
               nxt_next_fetch = script_ptr;
               if (insn_w0[POS_CLASS +: 2] == OP_BRANCH) begin
                  nxt_done      = 1'b1;
                  nxt_instr_reg = insn_w1;
                  nxt_sps       = insn_w1;
                  nxt_idle      = 1'b1;
                  case (insn_w0[POS_BROP +: 3])
                     BR_JUMP, BR_CALL: begin
                        if (insn_w0[POS_BROP +: 3] == BR_CALL) begin
                           nxt_dst = script_ptr;
                        end
                        if (take) begin
                           nxt_next_fetch = insn_w0[POS_REL]
                                            ? rel_target
                                            : insn_w1;
                        end
                     end
                     BR_RETURN: begin
                        if (take) begin
                           nxt_next_fetch = return_holder_ff;
                        end
                     end
                     BR_INT: begin
                        if (take) begin
                           nxt_int_req = 1'b1;
                           nxt_halt    = ~insn_w0[POS_INTFLY];
                        end
                     end
                     default: begin
                        nxt_illegal = 1'b1;
                     end
                  endcase
               end else if (insn_w0[POS_CLASS +: 2] == OP_MOVE) begin
                  if (insn_w1[1:0] != insn_w2[1:0]) begin
                     nxt_illegal = 1'b1;
                     nxt_done    = 1'b1;
                     nxt_idle    = 1'b1;
                  end else begin
                     // Upper six bits are left to software, not checked
                     nxt_count = insn_w0[COUNT_W-1:0];
                     nxt_src   = insn_w1;
                     nxt_dst   = insn_w2;
                     nxt_sps   = insn_w2;
                     nxt_state = ST_RD_START;
                  end
               end else begin
                  nxt_illegal = 1'b1;
                  nxt_done    = 1'b1;
                  nxt_idle    = 1'b1;
               end
            end
         end
         ST_RD_START: begin
            nxt_beats = 5'h00;
            if (byte_count_ff == RST_COUNT) begin
               nxt_done  = 1'b1;
               nxt_idle  = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_RD_XFER;
            end
         end
         ST_RD_XFER: begin
            if (ack) begin
               nxt_count = byte_count_ff - {21'h00_0000, rd_sz};
               nxt_src   = next_address_pointer_ff
                           + {29'h0000_0000, rd_sz};
               nxt_beats = beats_ff + 5'h01;
               if (nxt_beats == chunk || nxt_count == RST_COUNT) begin
                  nxt_state = ST_WR_START;
               end
            end else if (!xfer_busy && fifo_in_ready
                         && (cur_in_reg || bus_gnt)) begin
               if (cur_in_reg) begin
                  nxt_reg_re   = 1'b1;
                  nxt_reg_byte = rd_byte;
                  nxt_reg_addr = next_address_pointer_ff;
               end else begin
                  nxt_bus_stb  = 1'b1;
                  nxt_bus_we   = 1'b0;
                  nxt_bus_byte = rd_byte;
                  nxt_bus_addr = next_address_pointer_ff;
               end
            end
         end
         ST_WR_START: begin
            nxt_state = ST_WR_XFER;
         end
         ST_WR_XFER: begin
            if (ack) begin
               nxt_dst   = return_holder_ff
                           + {29'h0000_0000, wr_sz};
               nxt_beats = beats_ff - 5'h01;
               if (beats_ff == 5'h01) begin
                  nxt_state = ST_RD_START;
               end
            end else if (!xfer_busy && fifo_out_valid
                         && (cur_in_reg || bus_gnt)) begin
               if (cur_in_reg) begin
                  // Register writes follow the reads of each burst
                  nxt_reg_we    = 1'b1;
                  nxt_reg_byte  = fifo_out[32];
                  nxt_reg_addr  = return_holder_ff;
                  nxt_reg_wdata = fifo_out[31:0];
               end else begin
                  nxt_bus_stb   = 1'b1;
                  nxt_bus_we    = 1'b1;
                  nxt_bus_byte  = fifo_out[32];
                  nxt_bus_addr  = return_holder_ff;
                  nxt_bus_wdata = fifo_out[31:0];
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      // Bus is released between read and write halves, then won again
      nxt_bus_req = ((nxt_state == ST_RD_XFER)
                     || (nxt_state == ST_WR_XFER))
                    && !(state_ff == ST_RD_XFER
                         && nxt_state == ST_WR_START);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff                <= ST_IDLE;
         beats_ff                <= 5'h00;
         idle_ff                 <= 1'b0;
         done_ff                 <= 1'b0;
         next_fetch_ff           <= RST_ADDR;
         int_req_ff              <= 1'b0;
         halt_ff                 <= 1'b0;
         illegal_ff              <= 1'b0;
         instr_reg_ff            <= RST_ADDR;
         script_pointer_save_ff  <= RST_ADDR;
         next_address_pointer_ff <= RST_ADDR;
         return_holder_ff        <= RST_ADDR;
         byte_count_ff           <= RST_COUNT;
         bus_req_ff              <= 1'b0;
         bus_stb_ff              <= 1'b0;
         bus_we_ff               <= 1'b0;
         bus_byte_ff             <= 1'b0;
         bus_addr_ff             <= RST_ADDR;
         bus_wdata_ff            <= RST_ADDR;
         reg_re_ff               <= 1'b0;
         reg_we_ff               <= 1'b0;
         reg_byte_ff             <= 1'b0;
         reg_addr_ff             <= RST_ADDR;
         reg_wdata_ff            <= RST_ADDR;
      end else begin
         state_ff                <= nxt_state;
         beats_ff                <= nxt_beats;
         idle_ff                 <= nxt_idle;
         done_ff                 <= nxt_done;
         next_fetch_ff           <= nxt_next_fetch;
         int_req_ff              <= nxt_int_req;
         halt_ff                 <= nxt_halt;
         illegal_ff              <= nxt_illegal;
         instr_reg_ff            <= nxt_instr_reg;
         script_pointer_save_ff  <= nxt_sps;
         next_address_pointer_ff <= nxt_src;
         return_holder_ff        <= nxt_dst;
         byte_count_ff           <= nxt_count;
         bus_req_ff              <= nxt_bus_req;
         bus_stb_ff              <= nxt_bus_stb;
         bus_we_ff               <= nxt_bus_we;
         bus_byte_ff             <= nxt_bus_byte;
         bus_addr_ff             <= nxt_bus_addr;
         bus_wdata_ff            <= nxt_bus_wdata;
         reg_re_ff               <= nxt_reg_re;
         reg_we_ff               <= nxt_reg_we;
         reg_byte_ff             <= nxt_reg_byte;
         reg_addr_ff             <= nxt_reg_addr;
         reg_wdata_ff            <= nxt_reg_wdata;
      end
   end
endmodule
`default_nettype wire

// ---- inc/mmbe_pkg.sv ----
/*
 * Constants, field positions and state codes of the move and branch engine.
 * Assumes a single system clock and a synchronous active-high reset.
 */
// Notes on behaviour
// - Branch second word is an absolute address or signed 24-bit offset.
// - Return and interrupt ignore the target but still load it for firmware.
// - Data and phase compares together must both match the sense to branch.
// - No compare selected and sense bit one: branch unconditionally.
// - No compare selected and sense bit zero: no-operation, fall through.
// - First word bits 31-30 equal to 11 decode a memory move.
// - The 24-bit count of the first word loads the byte counter.
// - Each burst: win bus, read into FIFO, count down, then write out.
// - Bursts repeat until the count is zero at a read start.
// - Any direct byte count is accepted, odd ones included.
// - Source address lives in the next-address pointer, advanced per transfer.
// - Destination lives in the return-address holder, advanced per transfer.
// - Reads from own register space move one byte or whole longwords.
// - Writes into own register space take one byte or whole longwords.
// - Register source writes memory, register destination reads it, both copy.
// - Differing low two address bits raise an illegal-instruction condition.
// - Burst lengths of 2, 4, 8 or 16 longwords are supported.
// - A move overwrites the pointer-save and working address registers.
// - Writes into own registers come in the write half of each burst.
// - Relative jump or call adds the signed pointer-save value to pointer.
// - Sense one branches on match, sense zero branches on mismatch.
package mmbe_pkg;
   localparam logic [1:0] OP_BRANCH   = 2'h2;
   localparam logic [1:0] OP_MOVE     = 2'h3;
   localparam logic [2:0] BR_JUMP     = 3'h0;
   localparam logic [2:0] BR_CALL     = 3'h1;
   localparam logic [2:0] BR_RETURN   = 3'h2;
   localparam logic [2:0] BR_INT      = 3'h3;
   localparam int         POS_CLASS   = 30;
   localparam int         POS_BROP    = 27;
   localparam int         POS_PHASE   = 24;
   localparam int         POS_REL     = 23;
   localparam int         POS_INTFLY  = 20;
   localparam int         POS_SENSE   = 19;
   localparam int         POS_CMPDAT  = 18;
   localparam int         POS_CMPPHS  = 17;
   localparam int         POS_MASK    = 8;
   localparam int         COUNT_W     = 24;
   localparam logic [2:0] SZ_BYTE     = 3'h1;
   localparam logic [2:0] SZ_LWORD    = 3'h4;
   localparam logic [31:0] RST_ADDR   = 32'h0000_0000;
   localparam logic [23:0] RST_COUNT  = 24'h00_0000;

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_RD_START = 5'h02,
      ST_RD_XFER  = 5'h04,
      ST_WR_START = 5'h08,
      ST_WR_XFER  = 5'h10
   } mmbe_state_type;
endpackage

// ---- rtl/mmbe_fifo.sv ----
/*
 * Show-ahead FIFO with valid/ready on both sides.
 * Assumes one clock; the drain side may stall at will.
 */
`timescale 1ns/100ps
`default_nettype none
module mmbe_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ff;
   logic [AW-1:0]    rd_ff;
   logic [AW:0]      lvl_ff;
   logic [AW-1:0]    nxt_wr;
   logic [AW-1:0]    nxt_rd;
   logic [AW:0]      nxt_lvl;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two, at least 2");
   end

   assign in_ready  = (lvl_ff != DEPTH[AW:0]);
   assign out_valid = (lvl_ff != '0);
   assign out_data  = mem_ff[rd_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      nxt_wr  = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd  = pop ? rd_ff + 1'b1 : rd_ff;
      nxt_lvl = lvl_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         lvl_ff <= '0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         lvl_ff <= nxt_lvl;
      end
   end

   // Storage needs no reset; level guards every read
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/mmbe_branch_eval.sv ----
/*
 * Decides whether a transfer-control instruction is taken.
 * Assumes phase and data inputs hold the last valid values.
 */
`timescale 1ns/100ps
`default_nettype none
module mmbe_branch_eval
   import mmbe_pkg::*;
(
   input  wire logic [31:0] first_word,
   input  wire logic [2:0]  phase_lines,
   input  wire logic [7:0]  last_rx_byte,
   output logic             take
);
   logic sense;
   logic cmp_d;
   logic cmp_p;
   logic d_hit;
   logic p_hit;

   always_comb begin
      sense = first_word[POS_SENSE];
      cmp_d = first_word[POS_CMPDAT];
      cmp_p = first_word[POS_CMPPHS];
      // Set mask bits exclude a data bit from the compare
      d_hit = ((first_word[7:0] ^ last_rx_byte)
               & ~first_word[POS_MASK +: 8]) == 8'h00;
      p_hit = first_word[POS_PHASE +: 3] == phase_lines;
      if (cmp_d && cmp_p) begin
         take = (d_hit == p_hit) && (d_hit == sense);
      end else if (cmp_d) begin
         take = (d_hit == sense);
      end else if (cmp_p) begin
         take = (p_hit == sense);
      end else begin
         take = sense;
      end
   end
endmodule
`default_nettype wire

// ---- test/mmbe_engine_asserts.sv ----
/* Port checker for the move and branch engine.
   Bound to every mmbe_engine; one clock, synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module mmbe_engine_asserts
   import mmbe_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        insn_valid,
   input wire logic [31:0] insn_w0,
   input wire logic [31:0] insn_w1,
   input wire logic [31:0] insn_w2,
   input wire logic        idle_ff,
   input wire logic        done_ff,
   input wire logic        illegal_ff,
   input wire logic [23:0] byte_count_ff,
   input wire logic        bus_req_ff,
   input wire logic        bus_stb_ff,
   input wire logic        bus_we_ff,
   input wire logic        bus_byte_ff,
   input wire logic [31:0] bus_addr_ff,
   input wire logic        bus_ack
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic        acc, mv, ok;
   logic [23:0] n;
   assign n   = insn_w0[23:0];
   assign acc = insn_valid && idle_ff;
   assign mv  = acc && insn_w0[31:30] == OP_MOVE;
   assign ok  = insn_w1[1:0] == insn_w2[1:0];
   a_branch_done: assert property (acc &&
      insn_w0[31:30] == OP_BRANCH |=> done_ff) else $error("no done");
   a_count_load: assert property (mv && ok |=>
      byte_count_ff == $past(n)) else $error("count not loaded");
   a_zero_move: assert property (mv && ok && n == 24'h0 |=>
      !bus_req_ff ##1 done_ff && !bus_req_ff) else $error("zero move");
   a_misalign_flag: assert property (mv && !ok |=>
      ##[0:2] illegal_ff) else $error("misalign not flagged");
   a_stb_hold: assert property (bus_stb_ff && !bus_ack |=>
      bus_stb_ff && $stable(bus_addr_ff)) else $error("strobe dropped");
   a_stb_release: assert property (bus_stb_ff && bus_ack |=>
      !bus_stb_ff) else $error("strobe held after ack");
   a_req_gap: assert property ($fell(bus_req_ff) |->
      !bus_stb_ff [*2]) else $error("strobe in request gap");
   a_read_count: assert property (bus_stb_ff && bus_ack && !bus_we_ff |=>
      byte_count_ff == $past(byte_count_ff) -
      ($past(bus_byte_ff) ? 24'h1 : 24'h4)) else $error("count step");
endmodule
bind mmbe_engine mmbe_engine_asserts i_chk (.*);
`default_nettype wire

// ---- test/mmbe_sysbus_model.sv ----
/* System bus partner: longword memory with a settable ack delay.
   Driven by the engine's bus outputs; grant follows request. */
`timescale 1ns/100ps
`default_nettype none
module mmbe_sysbus_model (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [1:0]  lat,
   input  wire logic        bus_req_ff,
   input  wire logic        bus_stb_ff,
   input  wire logic        bus_we_ff,
   input  wire logic        bus_byte_ff,
   input  wire logic [31:0] bus_addr_ff,
   input  wire logic [31:0] bus_wdata_ff,
   output logic             bus_gnt,
   output logic [31:0]      bus_rdata,
   output logic             bus_ack
);
   logic [31:0] mem [int unsigned];
   logic [1:0]  wait_cnt = 2'h0;
   logic [4:0]  sh;
   initial bus_gnt = 1'b0;
   initial bus_ack = 1'b0;
   initial bus_rdata = 32'h0;
   always @(posedge sys_clk) begin
      sh = {bus_addr_ff[1:0], 3'h0};
      bus_gnt <= bus_req_ff && !srst;
      bus_ack <= 1'b0;
      // Idle data toggles so a stale read can never pass
      bus_rdata <= ~bus_rdata;
      if (bus_stb_ff && !bus_ack && !srst) begin
         wait_cnt <= wait_cnt + 2'h1;
         if (wait_cnt == lat) begin
            wait_cnt <= 2'h0;
            bus_ack <= 1'b1;
            bus_rdata <= mem[bus_addr_ff[31:2]];
            if (bus_we_ff && bus_byte_ff)
               mem[bus_addr_ff[31:2]][sh +: 8] = bus_wdata_ff[sh +: 8];
            else if (bus_we_ff)
               mem[bus_addr_ff[31:2]] = bus_wdata_ff;
         end
      end
   end
endmodule
`default_nettype wire

// ---- test/test_mmbe_engine.sv ----
/* Self-checking bench for mmbe_engine with a memory partner.
   Inputs change on the falling edge; own registers sit in the bench. */
`timescale 1ns/100ps
`default_nettype none
module test_mmbe_engine;
   import mmbe_pkg::*;
   localparam logic [31:0] RB = 32'hFFFF_FF00;
   localparam logic [31:0] SP = 32'h0000_1008;
   logic        sys_clk = 1'b0, srst = 1'b1, insn_valid = 1'b0;
   logic [31:0] insn_w0 = 32'h0, insn_w1 = 32'h0, insn_w2 = 32'h0;
   logic [31:0] script_ptr = SP;
   logic [2:0]  phase_lines = 3'h2;
   logic [7:0]  last_rx_byte = 8'h5A;
   logic [1:0]  burst_sel = 2'h0, lat = 2'h0;
   logic        idle_ff, done_ff, int_req_ff, halt_ff, illegal_ff, bus_gnt;
   logic        bus_req_ff, bus_stb_ff, bus_we_ff, bus_byte_ff, bus_ack;
   logic        reg_re_ff, reg_we_ff, reg_byte_ff, irq, hlt, ill;
   logic [31:0] next_fetch_ff, instr_reg_ff, script_pointer_save_ff;
   logic [31:0] next_address_pointer_ff, return_holder_ff, bus_addr_ff;
   logic [31:0] bus_wdata_ff, bus_rdata, reg_addr_ff, reg_wdata_ff;
   logic [31:0] reg_rdata;
   logic [23:0] byte_count_ff;
   logic [31:0] regs [32];
   logic [4:0]  rsh;
   int          n_mismatch = 0, checked = 0;
   mmbe_engine i_dut (.*);
   mmbe_sysbus_model i_mem (.*);
   always #12.5 sys_clk = ~sys_clk;
   assign rsh = {reg_addr_ff[1:0], 3'h0};
   assign reg_rdata = regs[reg_addr_ff[6:2]];
   always @(posedge sys_clk) begin
      if (reg_we_ff && reg_byte_ff)
         regs[reg_addr_ff[6:2]][rsh +: 8] <= reg_wdata_ff[rsh +: 8];
      else if (reg_we_ff)
         regs[reg_addr_ff[6:2]] <= reg_wdata_ff;
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic run(logic [31:0] w0, logic [31:0] w1, logic [31:0] w2);
      int t;
      insn_w0 = w0;
      insn_w1 = w1;
      insn_w2 = w2;
      insn_valid = 1'b1;
      @(negedge sys_clk) insn_valid = 1'b0;
      for (t = 0; t < 3000 && done_ff !== 1'b1; t++) @(negedge sys_clk);
      if (t == 3000) begin
         n_mismatch++;
         final_report();
      end
      irq = int_req_ff;
      hlt = halt_ff;
      ill = illegal_ff;
      @(negedge sys_clk);
   endtask
   function automatic logic [31:0] rdb(logic [31:0] a);
      if (a >= RB)
         return {24'h0, regs[a[6:2]][{a[1:0], 3'h0} +: 8]};
      return {24'h0, i_mem.mem[a[31:2]][{a[1:0], 3'h0} +: 8]};
   endfunction
   // Flags f: relative, sense, compare data, compare phase
   task automatic brc(logic [2:0] op, logic [3:0] f, logic [2:0] ph,
                      logic [7:0] dat, logic [31:0] w1, logic [31:0] exp);
      run({OP_BRANCH, op, ph, f[3], 3'h0, f[2:0], 9'h0, dat}, w1,
          32'h0);
      if (op != BR_INT)
         check("next fetch", next_fetch_ff, exp);
   endtask
   task automatic branches();
      brc(BR_JUMP, 4'h4, 3'h0, 8'h00, 32'h4000, 32'h4000);
      brc(BR_JUMP, 4'h0, 3'h0, 8'h00, 32'h4000, SP);
      brc(BR_JUMP, 4'h7, 3'h2, 8'h5A, 32'h4000, 32'h4000);
      brc(BR_JUMP, 4'h3, 3'h3, 8'h00, 32'h4000, 32'h4000);
      brc(BR_JUMP, 4'h7, 3'h2, 8'h00, 32'h4000, SP);
      brc(BR_JUMP, 4'h1, 3'h2, 8'h00, 32'h4000, SP);
      brc(BR_JUMP, 4'hC, 3'h0, 8'h00, 32'h00FF_FFF0, SP - 32'h10);
      brc(BR_RETURN, 4'h4, 3'h0, 8'h00, 32'h7777, RB + 32'h24);
      check("return word", instr_reg_ff, 32'h7777);
      brc(BR_CALL, 4'h4, 3'h0, 8'h00, 32'h6000, 32'h6000);
      brc(BR_INT, 4'h4, 3'h0, 8'h00, 32'hFF01, SP);
      check("int word", instr_reg_ff, 32'hFF01);
      check("int flags", {30'h0, irq, hlt}, 32'h3);
   endtask
   task automatic mvc(logic [23:0] n, logic [31:0] s, logic [31:0] d);
      run({OP_MOVE, 6'h00, n}, s, d);
      check("fetch", next_fetch_ff, SP);
      check("source", next_address_pointer_ff, s + n);
      check("dest", return_holder_ff, d + n);
      check("count", {8'h0, byte_count_ff}, 32'h0);
      for (int i = 0; i < n; i++) check("byte", rdb(d + i), rdb(s + i));
   endtask
   task automatic moves();
      mvc(24'd13, 32'h100, 32'h800);
      for (int b = 0; b < 4; b++) begin
         burst_sel = b[1:0];
         lat = b[1:0];
         mvc(24'd70, 32'h201 + b * 32'h80, 32'h901 + b * 32'h80);
      end
      run({OP_MOVE, 6'h00, 24'd8}, 32'h301, 32'h902);
      check("illegal", {31'h0, ill}, 32'h1);
      run({OP_MOVE, 6'h00, 24'd0}, 32'h100, 32'hA00);
      check("zero fetch", next_fetch_ff, SP);
      mvc(24'd4, RB + 32'h8, 32'hB00);
      mvc(24'd1, 32'h107, RB + 32'h13);
      mvc(24'd4, 32'h104, RB + 32'h10);
      mvc(24'd4, RB + 32'h4, RB + 32'h20);
   endtask
   initial begin
      for (int k = 0; k < 1024; k++) i_mem.mem[k] = 32'h9E37_79B9 * k;
      for (int k = 0; k < 32; k++) regs[k] = 32'hC0DE_0000 + k;
      repeat (6) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("idle", {31'h0, idle_ff}, 32'h1);
      moves();
      branches();
      final_report();
   end
endmodule
`default_nettype wire
